// ===== src/dvc_top.sv
// Functional notes
// - output clock delayed by phase field times the 700 ps step rounded up to whole clk cycles
// - quarter select alone divides the video clock by four
// - half select alone divides the video clock by two
// - both selects high give the undivided full-rate clock
// - disable field 11b tristates both pins; resets to 00b, driven
// - three-bit window limits counter drift from frame sync; resets 010b
// - rising load bit loads every non-zero custom ratio parameter
// - 384fs and 192fs outputs run only while mid-rate enable high
// - mid-rate enable at 96 kHz gives 512fs a one-third duty
// - custom parameters are 32-bit numerator and denominator, non-zero ratio
//
// register port, control state and pin drive for the block
// assumes ticks and frame sync come from logic on clk
`timescale 1ns/100ps
module dvc_top
  #(parameter int FRAME_TICKS = dvc_pkg::FRAME_TICKS_DEF,
    parameter int WIN_UNIT = dvc_pkg::WIN_UNIT_DEF)
  (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic vclk_tick,
  input wire logic audio_frame_sync_pulse,
  input wire logic audio_tick_512x6,
  input wire logic audio_tick_384x2,
  input wire logic fs_96k_pin,
  output logic diff_video_clock_out_p,
  output logic diff_video_clock_out_n,
  output logic diff_video_clock_oe,
  output logic audio_512fs,
  output logic audio_384fs,
  output logic audio_192fs,
  output logic [31:0] custom_num,
  output logic [31:0] custom_den,
  output logic custom_load,
  output logic drift_reset
  );
  import dvc_pkg::*;
  localparam logic [23:0] FRAME_L = 24'(FRAME_TICKS);

  typedef struct packed {
    logic [3:0] diff_clock_phase_delay;
    logic quarter_rate_select;
    logic half_rate_select;
    logic [1:0] dis;
    logic [2:0] audio_drift_window;
    logic load_bit;
    logic mid_rate_audio_enable;
    logic [15:0] num_lo;
    logic [15:0] num_hi;
    logic [15:0] den_lo;
    logic [15:0] den_hi;
    logic [31:0] act_num;
    logic [31:0] act_den;
    logic load_pulse;
    logic [23:0] acnt;
    logic drift_pulse;
    logic [15:0] rdata;
    logic pin_p;
    logic pin_n;
    logic oe;
    logic [1:0] fs_sync;
  } dvc_top_s;

  dvc_top_s s_r;
  dvc_top_s s_nxt;
  logic shaper_out;
  logic shaper_busy;
  logic [3:0] app_phase;
  logic [1:0] app_mode;
  logic [23:0] drift;
  logic [23:0] win_ticks;
  logic drift_big;
  logic load_rise;
  logic [31:0] num_stage;
  logic [31:0] den_stage;

  dvc_clk_shaper #(
    .STEPS(PHASE_STEPS)
  ) dvc_clk_shaper_i (
    .clk(clk),
    .rst_n(rst_n),
    .vclk_tick(vclk_tick),
    .phase_in(s_r.diff_clock_phase_delay),
    .mode_in({s_r.quarter_rate_select, s_r.half_rate_select}),
    .clk_out(shaper_out),
    .busy(shaper_busy),
    .app_phase(app_phase),
    .app_mode(app_mode)
  );

  dvc_audio_former dvc_audio_former_i (
    .clk(clk),
    .rst_n(rst_n),
    .tick_512x6(audio_tick_512x6),
    .tick_384x2(audio_tick_384x2),
    .mid_en(s_r.mid_rate_audio_enable),
    .fs_96k(s_r.fs_sync[1]),
    .a512(audio_512fs),
    .a384(audio_384fs),
    .a192(audio_192fs)
  );

  assign num_stage = {s_r.num_hi, s_r.num_lo};
  assign den_stage = {s_r.den_hi, s_r.den_lo};
  assign load_rise = wr && addr == ADDR_AUDIO_CTL && wdata[LOAD_BIT] && !s_r.load_bit;
  assign drift = (s_r.acnt > (FRAME_L >> 1)) ? FRAME_L - s_r.acnt : s_r.acnt;
  assign win_ticks = 24'(((int'(s_r.audio_drift_window)) + 1) * WIN_UNIT);
  assign drift_big = drift > win_ticks;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.load_pulse = 1'b0;
    s_nxt.drift_pulse = 1'b0;
    s_nxt.rdata = 16'h0000;
    s_nxt.fs_sync = {s_r.fs_sync[0], fs_96k_pin};
    // reserved bits are dropped on write and read back as zero
    if (wr)
    begin
      case (addr)
        ADDR_PHASE_DIV:
        begin
          s_nxt.diff_clock_phase_delay = wdata[PHASE_LSB +: 4];
          s_nxt.quarter_rate_select = wdata[QUARTER_BIT];
          s_nxt.half_rate_select = wdata[HALF_BIT];
        end
        ADDR_DISABLE: s_nxt.dis = wdata[1:0];
        ADDR_AUDIO_CTL:
        begin
          s_nxt.audio_drift_window = wdata[WIN_LSB +: 3];
          s_nxt.load_bit = wdata[LOAD_BIT];
          s_nxt.mid_rate_audio_enable = wdata[MID_BIT];
        end
        ADDR_NUM_LO: s_nxt.num_lo = wdata;
        ADDR_NUM_HI: s_nxt.num_hi = wdata;
        ADDR_DEN_LO: s_nxt.den_lo = wdata;
        ADDR_DEN_HI: s_nxt.den_hi = wdata;
        default: s_nxt.dis = s_r.dis;
      endcase
    end
    // a zero parameter keeps the ratio in use, so one half may be updated alone
    if (load_rise)
    begin
      s_nxt.load_pulse = 1'b1;
      if (num_stage != 32'h0000_0000)
        s_nxt.act_num = num_stage;
      if (den_stage != 32'h0000_0000)
        s_nxt.act_den = den_stage;
    end
    if (rd)
    begin
      case (addr)
        ADDR_PHASE_DIV:
          s_nxt.rdata = {10'h000, s_r.diff_clock_phase_delay,
                         s_r.quarter_rate_select, s_r.half_rate_select};
        ADDR_DISABLE: s_nxt.rdata = {14'h0000, s_r.dis};
        ADDR_AUDIO_CTL:
          s_nxt.rdata = {6'h00, s_r.audio_drift_window, s_r.load_bit,
                         s_r.mid_rate_audio_enable, 5'h00};
        ADDR_NUM_LO: s_nxt.rdata = s_r.num_lo;
        ADDR_NUM_HI: s_nxt.rdata = s_r.num_hi;
        ADDR_DEN_LO: s_nxt.rdata = s_r.den_lo;
        ADDR_DEN_HI: s_nxt.rdata = s_r.den_hi;
        ADDR_STATUS:
          s_nxt.rdata = {8'h00, app_phase, app_mode, shaper_busy, s_r.oe};
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
    // frame sync re-centres the counter only when drift exceeds the window
    if (audio_frame_sync_pulse && drift_big)
    begin
      s_nxt.acnt = 24'h000000;
      s_nxt.drift_pulse = 1'b1;
    end
    else if (audio_tick_512x6)
      s_nxt.acnt = (s_r.acnt == FRAME_L - 24'h000001) ? 24'h000000 : s_r.acnt + 24'h000001;
    // enable changes only while the clock is low to avoid a cut pulse
    if (!shaper_out)
      s_nxt.oe = (s_r.dis != DIS_TRISTATE);
    s_nxt.pin_p = s_nxt.oe & shaper_out;
    s_nxt.pin_n = s_nxt.oe & ~shaper_out;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.dis <= DIS_RST;
      s_r.audio_drift_window <= WIN_RST;
      s_r.oe <= 1'b1;
      s_r.pin_n <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign rdata = s_r.rdata;
  assign diff_video_clock_out_p = s_r.pin_p;
  assign diff_video_clock_out_n = s_r.pin_n;
  assign diff_video_clock_oe = s_r.oe;
  assign custom_num = s_r.act_num;
  assign custom_den = s_r.act_den;
  assign custom_load = s_r.load_pulse;
  assign drift_reset = s_r.drift_pulse;

  reset_values_a: assert property (@(posedge clk)
    !rst_n |=> s_r.dis == DIS_RST && s_r.audio_drift_window == WIN_RST && s_r.oe)
    else $error("reset values wrong");
  oe_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(s_r.oe) |-> $past(s_r.dis) == DIS_TRISTATE && !$past(shaper_out))
    else $error("pins released without tristate code");
  oe_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.dis == DIS_TRISTATE [*3] ##0 !shaper_out |=> !s_r.oe && !s_r.pin_p && !s_r.pin_n)
    else $error("pins still driven in tristate");
  disable_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd && addr == ADDR_DISABLE && !$past(wr) |=> rdata == {14'h0000, $past(s_r.dis)})
    else $error("disable field readback wrong");
  window_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr && addr == ADDR_AUDIO_CTL ##1 rd && addr == ADDR_AUDIO_CTL |=>
    rdata[WIN_LSB +: 3] == $past(wdata[WIN_LSB +: 3], 2))
    else $error("window readback wrong");
  load_nonzero_a: assert property (@(posedge clk) disable iff (!rst_n)
    load_rise && num_stage != 32'h0000_0000 |=> custom_num == $past(num_stage) && custom_load)
    else $error("custom numerator not loaded");
  load_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    load_rise && den_stage == 32'h0000_0000 |=> $stable(custom_den))
    else $error("zero denominator was loaded");
  no_level_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    !load_rise |=> $stable(custom_num) && !custom_load)
    else $error("ratio changed without rising edge");
  drift_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    audio_frame_sync_pulse && drift_big |=> s_r.acnt == 24'h000000 && drift_reset)
    else $error("drift past window not reset");
  drift_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    audio_frame_sync_pulse && !drift_big |=> !drift_reset)
    else $error("counter reset inside window");
endmodule // dvc_top

// ===== src/dvc_pkg.sv
// shared constants for the differential clock and audio control block
// assumes a single 50 MHz clock and a 16-bit register port
package dvc_pkg;
  localparam logic [7:0] ADDR_PHASE_DIV = 8'h2E;
  localparam logic [7:0] ADDR_DISABLE = 8'h2F;
  localparam logic [7:0] ADDR_AUDIO_CTL = 8'h31;
  localparam logic [7:0] ADDR_NUM_LO = 8'h33;
  localparam logic [7:0] ADDR_NUM_HI = 8'h34;
  localparam logic [7:0] ADDR_DEN_LO = 8'h35;
  localparam logic [7:0] ADDR_DEN_HI = 8'h36;
  localparam logic [7:0] ADDR_STATUS = 8'h3E;
  localparam int PHASE_LSB = 2;
  localparam int QUARTER_BIT = 1;
  localparam int HALF_BIT = 0;
  localparam int WIN_LSB = 7;
  localparam int LOAD_BIT = 6;
  localparam int MID_BIT = 5;
  localparam logic [1:0] DIS_RST = 2'h0;
  localparam logic [1:0] DIS_TRISTATE = 2'h3;
  localparam logic [2:0] WIN_RST = 3'h2;
  localparam logic [1:0] MODE_HALF = 2'h1;
  localparam logic [1:0] MODE_QUARTER = 2'h2;
  localparam int PHASE_STEP_PS = 700;
  localparam int CLK_PERIOD_PS = 20000;
  localparam int STEP_CYC = (PHASE_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PHASE_STEPS = 15;
  localparam logic [2:0] TICKS_PER_512 = 3'h6;
  localparam logic [2:0] HIGH_50 = 3'h3;
  localparam logic [2:0] HIGH_33 = 3'h2;
  localparam int FRAME_TICKS_DEF = 5898240;
  localparam int WIN_UNIT_DEF = 6;

  typedef enum logic {SH_RUN = 1'b0, SH_DRAIN = 1'b1} dvc_shape_e;

  // input ticks per half period of the generated clock
  function automatic logic [2:0] dvc_half_ticks(input logic [1:0] mode);
    case (mode)
      MODE_HALF: dvc_half_ticks = 3'h2;
      MODE_QUARTER: dvc_half_ticks = 3'h4;
      default: dvc_half_ticks = 3'h1;
    endcase
  endfunction
endpackage

// ===== src/dvc_clk_shaper.sv
// divider and phase delay for the differential video clock
// assumes vclk_tick is a one-cycle enable from same-clock logic
`timescale 1ns/100ps
module dvc_clk_shaper
  #(parameter int STEPS = dvc_pkg::PHASE_STEPS)
  (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic vclk_tick,
  input wire logic [3:0] phase_in,
  input wire logic [1:0] mode_in,
  output logic clk_out,
  output logic busy,
  output logic [3:0] app_phase,
  output logic [1:0] app_mode
  );
  import dvc_pkg::*;
  localparam int DEPTH = STEPS * STEP_CYC;
  typedef struct packed {
    dvc_shape_e st;
    logic [1:0] cnt;
    logic gen;
    logic [DEPTH-1:0] line;
    logic [7:0] drain;
    logic [3:0] phase;
    logic [1:0] mode;
    logic out;
  } dvc_shaper_s;
  dvc_shaper_s s_r;
  dvc_shaper_s s_nxt;
  logic [2:0] half;

  always_comb
  begin
    s_nxt = s_r;
    half = dvc_half_ticks(s_r.mode);
    s_nxt.line = {s_r.line[DEPTH-2:0], s_r.gen};
    if (s_r.phase == 4'h0)
      s_nxt.out = s_r.gen;
    else
      s_nxt.out = s_r.line[int'(s_r.phase) * STEP_CYC - 1];
    case (s_r.st)
      SH_RUN:
      begin
        // new settings wait for a low level, then the line drains: no runt
        if (!s_r.gen && (phase_in != s_r.phase || mode_in != s_r.mode))
        begin
          s_nxt.st = SH_DRAIN;
          s_nxt.drain = 8'(DEPTH);
        end
        else if (vclk_tick)
        begin
          if ({1'b0, s_r.cnt} == half - 3'h1)
          begin
            s_nxt.cnt = 2'h0;
            s_nxt.gen = ~s_r.gen;
          end
          else
            s_nxt.cnt = s_r.cnt + 2'h1;
        end
      end
      SH_DRAIN:
      begin
        if (s_r.drain == 8'h00)
        begin
          s_nxt.phase = phase_in;
          s_nxt.mode = mode_in;
          s_nxt.cnt = 2'h0;
          s_nxt.st = SH_RUN;
        end
        else
          s_nxt.drain = s_r.drain - 8'h01;
      end
      default: s_nxt.st = SH_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign clk_out = s_r.out;
  assign busy = (s_r.st == SH_DRAIN);
  assign app_phase = s_r.phase;
  assign app_mode = s_r.mode;

  div_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(s_r.gen) && $past(s_r.st) == SH_RUN |->
    $past(vclk_tick) && $past({1'b0, s_r.cnt}) == $past(half) - 3'h1)
    else $error("clock toggled off its divide count");
  zero_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.phase == 4'h0 && $past(s_r.phase) == 4'h0 |-> s_r.out == $past(s_r.gen))
    else $error("zero phase output not aligned");
endmodule // dvc_clk_shaper

// ===== src/dvc_audio_former.sv
// forms the 512fs, 384fs and 192fs audio clock levels
// assumes tick inputs are one-cycle enables from same-clock logic
`timescale 1ns/100ps
module dvc_audio_former
  (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick_512x6,
  input wire logic tick_384x2,
  input wire logic mid_en,
  input wire logic fs_96k,
  output logic a512,
  output logic a384,
  output logic a192
  );
  import dvc_pkg::*;
  typedef struct packed {
    logic [2:0] c6;
    logic a512;
    logic a384;
    logic a192;
  } dvc_former_s;
  dvc_former_s s_r;
  dvc_former_s s_nxt;
  logic [2:0] high;

  always_comb
  begin
    s_nxt = s_r;
    high = (mid_en && fs_96k) ? HIGH_33 : HIGH_50;
    if (tick_512x6)
      s_nxt.c6 = (s_r.c6 == TICKS_PER_512 - 3'h1) ? 3'h0 : s_r.c6 + 3'h1;
    s_nxt.a512 = (s_nxt.c6 < high);
    if (!mid_en)
    begin
      s_nxt.a384 = 1'b0;
      s_nxt.a192 = 1'b0;
    end
    else if (tick_384x2)
    begin
      s_nxt.a384 = ~s_r.a384;
      if (!s_r.a384)
        s_nxt.a192 = ~s_r.a192;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign a512 = s_r.a512;
  assign a384 = s_r.a384;
  assign a192 = s_r.a192;

  duty_third_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(mid_en && fs_96k) && s_r.c6 == 3'h2 |-> !s_r.a512)
    else $error("512fs high too long at 96k");
  duty_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(!(mid_en && fs_96k)) && s_r.c6 == 3'h2 |-> s_r.a512)
    else $error("512fs duty not half");
  mid_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !mid_en |=> !s_r.a384 && !s_r.a192)
    else $error("mid rate outputs active while disabled");
endmodule // dvc_audio_former

// ===== dv/dvc_video_sink.sv
// downstream video logic model: times the levels of the differential clock pair
// assumes the pair is sampled once per clk edge
`timescale 1ns/100ps
module dvc_video_sink
  (
  input wire logic clk,
  input wire logic clk_p,
  input wire logic clk_n,
  input wire logic oe,
  input wire logic clr,
  output int half_len,
  output int min_half,
  output int pair_bad
  );
  int run;
  logic last;
  initial
  begin
    run = 0;
    half_len = 0;
    min_half = 99;
    pair_bad = 0;
    last = 1'b0;
  end
  // a sink only listens, so a runt pulse shows up as a short run length
  always @(posedge clk)
  begin
    last <= clk_p;
    if (oe && clk_p === clk_n)
      pair_bad <= pair_bad + 1;
    if (clk_p !== last)
    begin
      half_len <= run;
      run <= 1;
      if (run < min_half)
        min_half <= run;
    end
    else
      run <= run + 1;
    if (clr)
      min_half <= 99;
  end
endmodule // dvc_video_sink

// ===== dv/test_dvc_top.sv
// self-checking bench for dvc_top: register port, clock pair, audio clocks, drift
// assumes one 50 MHz clock; tick sources are made here on clk
`timescale 1ns/100ps
module test_dvc_top;
  import dvc_pkg::*;
  localparam int FT = 600;
  localparam int WU = 6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic vt = 1'b0, sync = 1'b0, t512 = 1'b0, t384 = 1'b0, fs96 = 1'b0, clr = 1'b0;
  logic run_v = 1'b1, one_v = 1'b0, run_a = 1'b1, man = 1'b0, men = 1'b0;
  logic p, n, oe, a512, a384, a192, cload, dres, l384, l192;
  logic [31:0] num, den;
  int n_fail = 0;
  int compares = 0;
  int half_len, min_half, pair_bad;
  int loads = 0, resets = 0, c384 = 0, c192 = 0, hi = 0, acyc = 0;

  initial forever #10 clk = ~clk;

  dvc_top #(.FRAME_TICKS(FT), .WIN_UNIT(WU)) dvc_top_i (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vclk_tick(vt), .audio_frame_sync_pulse(sync),
    .audio_tick_512x6(t512), .audio_tick_384x2(t384), .fs_96k_pin(fs96), .diff_video_clock_out_p(p),
    .diff_video_clock_out_n(n), .diff_video_clock_oe(oe), .audio_512fs(a512), .audio_384fs(a384),
    .audio_192fs(a192), .custom_num(num), .custom_den(den), .custom_load(cload), .drift_reset(dres));

  dvc_video_sink dvc_video_sink_i (.clk(clk), .clk_p(p), .clk_n(n), .oe(oe), .clr(clr),
    .half_len(half_len), .min_half(min_half), .pair_bad(pair_bad));

  // the hi, c384 and c192 counters clear whenever no window is open, so tasks never race them
  always @(posedge clk)
  begin
    acyc <= acyc + 1;
    vt <= run_v | one_v;
    t512 <= run_a ? (acyc % 2 == 0) : man;
    t384 <= run_a & (acyc % 8 == 0);
    l384 <= a384;
    l192 <= a192;
    if (cload === 1'b1)
      loads <= loads + 1;
    if (dres === 1'b1)
      resets <= resets + 1;
    hi <= men ? hi + (a512 === 1'b1) : 0;
    c384 <= men ? c384 + (a384 !== l384) : 0;
    c192 <= men ? c192 + (a192 !== l192) : 0;
  end

  task automatic final_report();
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // write then read with no gap between the strobes
  task automatic wrrd(input string nm, input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rdr(a, d);
    chk(nm, e, d);
  endtask

  // settings apply only after the drain, so poll the applied value
  task automatic settle(input logic [5:0] v);
    logic [15:0] d;
    for (int i = 0; i < 60; i++)
    begin
      rdr(ADDR_STATUS, d);
      if (d[7:2] === v)
        return;
    end
    chk("applied", v, d[7:2]);
    final_report();
  endtask

  task automatic t_regs();
    rdc("phase_div", ADDR_PHASE_DIV, 16'h0000);
    rdc("disable", ADDR_DISABLE, 16'h0000);
    rdc("audio_ctl", ADDR_AUDIO_CTL, 16'h0100);
    chk("oe", 1'b1, oe);
    wrr(8'h30, 16'hFFFF);
    rdc("unmapped", 8'h30, 16'h0000);
    wrr(ADDR_PHASE_DIV, 16'h003F);
    rdc("phase_div", ADDR_PHASE_DIV, 16'h003F);
    wrr(ADDR_DISABLE, 16'h0002);
    rdc("disable", ADDR_DISABLE, 16'h0002);
    wrrd("audio_ctl", ADDR_AUDIO_CTL, 16'h03A0, 16'h03A0);
    wrr(ADDR_AUDIO_CTL, 16'h0100);
    wrr(ADDR_PHASE_DIV, 16'h0000);
    settle(6'h00);
  endtask

  task automatic t_modes();
    logic [1:0] m [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    int h [4] = '{4, 2, 1, 1};
    for (int i = 0; i < 4; i++)
    begin
      clr <= 1'b1;
      wrr(ADDR_PHASE_DIV, {14'h0000, m[i]});
      clr <= 1'b0;
      settle({4'h0, m[i]});
      cyc(60);
      chk("half_len", h[i], half_len);
      if (i == 1)
        chk("min_half", 2, min_half);
    end
    chk("pair_bad", 0, pair_bad);
  endtask

  // one lone tick with the generator stopped; latency grows with the phase
  task automatic meas(output int d);
    logic p0;
    run_v <= 1'b0;
    cyc(20);
    #1 p0 = p;
    one_v <= 1'b1;
    @(posedge clk);
    one_v <= 1'b0;
    d = 0;
    while (p === p0 && d < 60)
    begin
      @(posedge clk);
      #1 d++;
    end
    run_v <= 1'b1;
  endtask

  task automatic t_phase();
    int d0, d;
    int k [2] = '{5, 15};
    meas(d0);
    foreach (k[i])
    begin
      wrr(ADDR_PHASE_DIV, 16'(k[i] << PHASE_LSB));
      settle(6'(k[i] << 2));
      meas(d);
      chk("phase_delay", k[i] * STEP_CYC, d - d0);
    end
    wrr(ADDR_PHASE_DIV, 16'h0000);
    settle(6'h00);
  endtask

  task automatic t_tristate();
    for (int v = 0; v < 5; v++)
    begin
      wrr(ADDR_DISABLE, 16'(v % 4));
      cyc(30);
      #1 chk("oe", v != 3, oe);
      if (v == 3)
        chk("pins", 2'b00, {p, n});
    end
  endtask

  task automatic t_load();
    int c0;
    c0 = loads;
    wrr(ADDR_NUM_LO, 16'h1234);
    wrr(ADDR_NUM_HI, 16'hABCD);
    wrr(ADDR_DEN_LO, 16'h0000);
    wrr(ADDR_DEN_HI, 16'h0000);
    wrr(ADDR_AUDIO_CTL, 16'h0140);
    cyc(2);
    chk("loads", c0 + 1, loads);
    chk("num", 32'hABCD1234, num);
    chk("den", 32'h0, den);
    wrr(ADDR_DEN_LO, 16'h0005);
    wrr(ADDR_AUDIO_CTL, 16'h0140);
    cyc(2);
    chk("loads", c0 + 1, loads);
    wrr(ADDR_AUDIO_CTL, 16'h0100);
    wrr(ADDR_AUDIO_CTL, 16'h0140);
    cyc(2);
    chk("loads", c0 + 2, loads);
    chk("den", 32'h5, den);
    chk("num", 32'hABCD1234, num);
    wrr(ADDR_AUDIO_CTL, 16'h0100);
  endtask

  // 240 cycles hold whole 512fs and 384fs periods and whole 192fs half periods, so counts are exact
  task automatic meas_a(input int e384, input int e192, input int ehi);
    cyc(30);
    men <= 1'b1;
    cyc(240);
    men <= 1'b0;
    #1 chk("toggles_384", e384, c384);
    chk("toggles_192", e192, c192);
    chk("high_512", ehi, hi);
  endtask

  task automatic t_audio();
    meas_a(0, 0, 120);
    wrr(ADDR_AUDIO_CTL, 16'h0120);
    meas_a(30, 15, 120);
    fs96 <= 1'b1;
    meas_a(30, 15, 80);
    wrr(ADDR_AUDIO_CTL, 16'h0100);
    meas_a(0, 0, 120);
    fs96 <= 1'b0;
  endtask

  task automatic send(input int k);
    repeat (k)
    begin
      man <= 1'b1;
      @(posedge clk);
      man <= 1'b0;
      @(posedge clk);
    end
    cyc(2);
  endtask

  task automatic sy(input int e);
    int r0;
    r0 = resets;
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    cyc(4);
    if (e >= 0)
      chk("drift_reset", e, resets - r0);
  endtask

  task automatic t_drift();
    run_a <= 1'b0;
    cyc(4);
    sy(-1);
    send(300);
    sy(1);
    send(3 * WU);
    sy(0);
    send(FT - 3 * WU);
    sy(0);
    send(3 * WU + 1);
    sy(1);
    wrr(ADDR_AUDIO_CTL, 16'h0380);
    send(8 * WU);
    sy(0);
    wrr(ADDR_AUDIO_CTL, 16'h0100);
    run_a <= 1'b1;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_phase();
    t_tristate();
    t_load();
    t_audio();
    t_drift();
    final_report();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    chk("timeout", 0, 1);
    final_report();
  end
endmodule // test_dvc_top
